/* File: hw/gts_pkg.sv */
/*
 * Constants for the general timer set: register offsets, control field
 * positions, writable masks, reset values and prescale limits.
 * Assumes a 32-bit APB slave with one register per aligned word.
 */
package gts_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_T1_CTRL = 8'h00;
    localparam logic [7:0] OFS_T1_CNT = 8'h04;
    localparam logic [7:0] OFS_T1_PER = 8'h08;
    localparam logic [7:0] OFS_T2_CTRL = 8'h0C;
    localparam logic [7:0] OFS_T3_CTRL = 8'h10;
    localparam logic [7:0] OFS_LO_CNT = 8'h14;
    localparam logic [7:0] OFS_UP_CNT = 8'h18;
    localparam logic [7:0] OFS_LO_PER = 8'h1C;
    localparam logic [7:0] OFS_UP_PER = 8'h20;
    localparam logic [7:0] OFS_FLAGS = 8'h24;
    localparam logic [7:0] OFS_IRQ_EN = 8'h28;
    // Decoded register selectors
    localparam logic [3:0] SEL_NONE = 4'hF;
    localparam logic [3:0] SEL_FLAGS = 4'h9;
    localparam logic [3:0] SEL_IRQ_EN = 4'hA;
    // Control field positions
    localparam int RUN_BIT = 15;
    localparam int SIDL_BIT = 13;
    localparam int GATE_BIT = 6;
    localparam int PS_HI = 5;
    localparam int PS_LO = 4;
    localparam int CHAIN_BIT = 3;
    localparam int SYNC_BIT = 2;
    localparam int TCS_BIT = 1;
    // Writable bits per control register, others read zero
    localparam logic [15:0] T1_MASK = 16'hA076;
    localparam logic [15:0] T2_MASK = 16'hA07A;
    localparam logic [15:0] T3_MASK = 16'hA072;
    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] PER_RST = 16'hFFFF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    // Prescale terminal counts for 1:256, 1:64, 1:8, 1:1
    localparam logic [7:0] PS256_MAX = 8'hFF;
    localparam logic [7:0] PS64_MAX = 8'h3F;
    localparam logic [7:0] PS8_MAX = 8'h07;
    localparam logic [7:0] PS1_MAX = 8'h00;
    // Flag and enable bit positions
    localparam int FLG_T1 = 0;
    localparam int FLG_LO = 1;
    localparam int FLG_UP = 2;
endpackage

/* File: hw/gts_timer_set.sv */
/*
 * General timer set: a standalone 16-bit timer and a lower/upper pair
 * that runs as two 16-bit timers or one chained 32-bit timer, with an
 * APB register file, interrupt requests and an ADC trigger pulse.
 * Assumes count pins, gate inputs and power-mode levels are synchronous
 * to mclk; the synchroniser stages model the sync/async choice.
 */
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: Timer1 run bit starts and stops it
// R2: Stop-in-idle bit halts timer in Idle
// R3: Gate counts internal clock only while active
// R4: Prescale codes give 1:256, 1:64, 1:8, 1:1
// R5: Sync bit chooses synchronized or asynchronous counting
// R6: Timer1 clock source selects pin or internal
// R7: Timer1 timer, sync counter, async counter modes
// R8: Interrupt on period match or gate fall
// R9: Timer1 may keep running in Idle, Sleep
// R10: Chain bit joins pair into 32 bits
// R11: Lower holds low word, upper high word
// R12: Chained timer obeys only lower control bits
// R13: Chained interrupt uses upper timer flag, enable
// R14: Period is upper:lower period registers
// R15: Count readable as upper:lower count pair
// R16: Separated pair timers never count asynchronously
// R17: Chained pair timer/counter interrupts on 32-bit match
// R18: ADC trigger only from chained pair
// R19: Lower and upper counts form time bases
// R20: Lower run bit runs chain or lower
// R21: Lower clock source selects pin or internal
// R22: Software sets run bit last
// R23: Software clears upper stop-in-idle for chain
// R24: Match resets counter, sets interrupt flag
module gts_timer_set
    import gts_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Count and gate pins
    input wire logic timer1_count_pin,
    input wire logic timer2_count_pin,
    input wire logic timer3_count_pin,
    // Processor power modes
    input wire logic idle_mode,
    input wire logic sleep_mode,
    // Interrupt requests and ADC trigger
    output logic timer1_irq,
    output logic lower_irq,
    output logic upper_irq,
    output logic adc_trigger,
    // Time bases for capture and compare
    output logic [15:0] lower_timebase,
    output logic [15:0] upper_timebase
);

    logic [15:0] con_reg [3];
    logic [15:0] cnt_reg [3];
    logic [15:0] per_reg [3];
    logic [2:0] flag_reg;
    logic [2:0] ien_reg;
    logic [2:0] flag_set;
    logic [2:0] pin_in;
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic [2:0] pin_old_reg;
    logic [2:0] pin_raw_reg;
    logic [2:0] inc;
    logic [2:0] gate_fall;
    logic [2:0] match16;
    logic [7:0] ps_reg [3];
    logic chain;
    logic match32;
    logic acc_wr;
    logic [3:0] wsel;
    logic [3:0] rsel;

    // Maps a byte offset onto a register selector
    function automatic logic [3:0] reg_sel(input logic [7:0] a);
        case (a)
            OFS_T1_CTRL: reg_sel = 4'h0;
            OFS_T2_CTRL: reg_sel = 4'h1;
            OFS_T3_CTRL: reg_sel = 4'h2;
            OFS_T1_CNT: reg_sel = 4'h3;
            OFS_LO_CNT: reg_sel = 4'h4;
            OFS_UP_CNT: reg_sel = 4'h5;
            OFS_T1_PER: reg_sel = 4'h6;
            OFS_LO_PER: reg_sel = 4'h7;
            OFS_UP_PER: reg_sel = 4'h8;
            OFS_FLAGS: reg_sel = SEL_FLAGS;
            OFS_IRQ_EN: reg_sel = SEL_IRQ_EN;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction

    // Terminal count of the prescaler for a prescale code
    function automatic logic [7:0] ps_max(input logic [1:0] code);
        case (code)
            2'b11: ps_max = PS256_MAX; // R4
            2'b10: ps_max = PS64_MAX;
            2'b01: ps_max = PS8_MAX;
            default: ps_max = PS1_MAX;
        endcase
    endfunction

    assign chain = con_reg[1][CHAIN_BIT]; // R10
    assign acc_wr = psel & penable & pready & pwrite;
    assign wsel = reg_sel(paddr);
    assign rsel = reg_sel(paddr);
    assign pin_in = {timer3_count_pin, timer2_count_pin, timer1_count_pin};
    // Chained period compare on the joined words
    assign match32 = ({cnt_reg[2], cnt_reg[1]} == {per_reg[2], per_reg[1]}); // R14 R17

    // Pin pipeline: two-stage synchroniser plus raw history
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
            pin_old_reg <= 3'h0;
            pin_raw_reg <= 3'h0;
        end
        else
        begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_old_reg <= pin_s2_reg;
            pin_raw_reg <= pin_in;
        end
    end

    // Per-timer clock selection, gating, power modes and prescaler
    for (genvar i = 0; i < 3; i++)
    begin : g_front
        logic [15:0] cfg;
        logic use_async;
        logic ext_edge;
        logic src;
        logic enable;
        logic fall_raw;
        // Upper timer follows lower control bits when chained
        assign cfg = (i == 2 && chain) ? con_reg[1] : con_reg[i]; // R12
        // Only the standalone timer may bypass the synchroniser
        assign use_async = (i == 0) && cfg[TCS_BIT] && !cfg[SYNC_BIT]; // R5 R7 R16
        assign ext_edge = use_async ? (pin_in[i] & ~pin_raw_reg[i])
                                    : (pin_s2_reg[i] & ~pin_old_reg[i]); // R6 R21
        // Gate only applies with the internal clock
        assign src = cfg[TCS_BIT] ? ext_edge
                   : (!cfg[GATE_BIT] || pin_s2_reg[i]); // R3
        // Sleep stops the instruction clock; only async counting survives
        assign enable = cfg[RUN_BIT] && !(idle_mode && cfg[SIDL_BIT])
                        && !(sleep_mode && !use_async); // R1 R2 R9 R20
        assign fall_raw = ~pin_s2_reg[i] & pin_old_reg[i];
        assign gate_fall[i] = enable && !cfg[TCS_BIT] && cfg[GATE_BIT] && fall_raw; // R8
        assign match16[i] = (cnt_reg[i] == per_reg[i]);
        assign inc[i] = enable && src && (ps_reg[i] == ps_max(cfg[PS_HI:PS_LO]));

        // Prescaler divides the selected input clock
        always_ff @(posedge mclk or negedge reset_n)
        begin
            if (!reset_n)
                ps_reg[i] <= PS1_MAX;
            else if (!cfg[RUN_BIT])
                ps_reg[i] <= PS1_MAX; // Clear so restart is deterministic
            else if (enable && src)
                ps_reg[i] <= inc[i] ? PS1_MAX : ps_reg[i] + 8'h01; // R4
        end
    end

    // Standalone timer counter; software write wins over counting
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            cnt_reg[0] <= CNT_RST;
        else if (acc_wr && wsel == 4'h3)
            cnt_reg[0] <= pwdata[15:0];
        else if (inc[0])
            cnt_reg[0] <= match16[0] ? CNT_RST : cnt_reg[0] + 16'h0001; // R24
    end

    // Lower and upper counters, chained or independent
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_reg[1] <= CNT_RST;
            cnt_reg[2] <= CNT_RST;
        end
        else if (chain)
        begin
            if (acc_wr && wsel == 4'h4)
                cnt_reg[1] <= pwdata[15:0];
            else if (inc[1])
                cnt_reg[1] <= match32 ? CNT_RST : cnt_reg[1] + 16'h0001; // R11 R24
            if (acc_wr && wsel == 4'h5)
                cnt_reg[2] <= pwdata[15:0];
            else if (inc[1] && match32)
                cnt_reg[2] <= CNT_RST;
            else if (inc[1] && cnt_reg[1] == CNT_MAX)
                cnt_reg[2] <= cnt_reg[2] + 16'h0001; // R11
        end
        else
        begin
            if (acc_wr && wsel == 4'h4)
                cnt_reg[1] <= pwdata[15:0];
            else if (inc[1])
                cnt_reg[1] <= match16[1] ? CNT_RST : cnt_reg[1] + 16'h0001; // R24
            if (acc_wr && wsel == 4'h5)
                cnt_reg[2] <= pwdata[15:0];
            else if (inc[2])
                cnt_reg[2] <= match16[2] ? CNT_RST : cnt_reg[2] + 16'h0001; // R24
        end
    end

    // Flag sources; chained events land on the upper flag
    assign flag_set[FLG_T1] = (inc[0] && match16[0]) || gate_fall[0]; // R8
    assign flag_set[FLG_LO] = !chain && ((inc[1] && match16[1]) || gate_fall[1]);
    assign flag_set[FLG_UP] = chain ? ((inc[1] && match32) || gate_fall[1])
                            : ((inc[2] && match16[2]) || gate_fall[2]); // R13

    // Flags clear by writing one; a same-cycle event keeps the flag set
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            flag_reg <= 3'h0;
        else if (acc_wr && wsel == SEL_FLAGS)
            flag_reg <= (flag_reg & ~pwdata[2:0]) | flag_set;
        else
            flag_reg <= flag_reg | flag_set; // R24
    end

    // Control, period and enable registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            con_reg[0] <= CTRL_RST;
            con_reg[1] <= CTRL_RST;
            con_reg[2] <= CTRL_RST;
            per_reg[0] <= PER_RST;
            per_reg[1] <= PER_RST;
            per_reg[2] <= PER_RST;
            ien_reg <= 3'h0;
        end
        else if (acc_wr)
        begin
            case (wsel)
                4'h0: con_reg[0] <= pwdata[15:0] & T1_MASK;
                4'h1: con_reg[1] <= pwdata[15:0] & T2_MASK;
                4'h2: con_reg[2] <= pwdata[15:0] & T3_MASK;
                4'h6: per_reg[0] <= pwdata[15:0];
                4'h7: per_reg[1] <= pwdata[15:0];
                4'h8: per_reg[2] <= pwdata[15:0];
                SEL_IRQ_EN: ien_reg <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // APB answer: ready in the first access cycle, data read at setup
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            pready <= 1'b1;
            pslverr <= (rsel == SEL_NONE);
            case (rsel)
                4'h0: prdata <= {16'h0000, con_reg[0]};
                4'h1: prdata <= {16'h0000, con_reg[1]};
                4'h2: prdata <= {16'h0000, con_reg[2]};
                4'h3: prdata <= {16'h0000, cnt_reg[0]};
                4'h4: prdata <= {16'h0000, cnt_reg[1]}; // R15
                4'h5: prdata <= {16'h0000, cnt_reg[2]}; // R15
                4'h6: prdata <= {16'h0000, per_reg[0]};
                4'h7: prdata <= {16'h0000, per_reg[1]};
                4'h8: prdata <= {16'h0000, per_reg[2]};
                SEL_FLAGS: prdata <= {29'h0000_0000, flag_reg};
                SEL_IRQ_EN: prdata <= {29'h0000_0000, ien_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Registered outputs: requests, ADC pulse and time bases
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timer1_irq <= 1'b0;
            lower_irq <= 1'b0;
            upper_irq <= 1'b0;
            adc_trigger <= 1'b0;
            lower_timebase <= CNT_RST;
            upper_timebase <= CNT_RST;
        end
        else
        begin
            timer1_irq <= flag_reg[FLG_T1] & ien_reg[FLG_T1];
            lower_irq <= flag_reg[FLG_LO] & ien_reg[FLG_LO];
            upper_irq <= flag_reg[FLG_UP] & ien_reg[FLG_UP]; // R13
            adc_trigger <= chain && inc[1] && match32; // R18
            lower_timebase <= cnt_reg[1]; // R19
            upper_timebase <= cnt_reg[2]; // R19
        end
    end

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    run_stop_a: assert property (!con_reg[0][RUN_BIT] && !(acc_wr && wsel == 4'h3)
        |=> $stable(cnt_reg[0])) else $error("timer1 counted while stopped"); // R1
    idle_halt_a: assert property (idle_mode && con_reg[0][SIDL_BIT] && !(acc_wr && wsel == 4'h3)
        |=> $stable(cnt_reg[0])) else $error("timer1 counted in idle"); // R2
    gate_block_a: assert property (con_reg[0][RUN_BIT] && !con_reg[0][TCS_BIT]
        && con_reg[0][GATE_BIT] && !pin_s2_reg[0] |-> !inc[0])
        else $error("gated timer counted with gate low"); // R3
    presc_bound_a: assert property (ps_reg[0] <= ps_max(con_reg[0][PS_HI:PS_LO])
        || !con_reg[0][RUN_BIT]) else $error("prescaler beyond ratio"); // R4
    match_reset_a: assert property (inc[0] && match16[0] && !(acc_wr && wsel == 4'h3)
        |=> cnt_reg[0] == CNT_RST && flag_reg[FLG_T1])
        else $error("timer1 match did not reset"); // R24
    carry_up_a: assert property (chain && inc[1] && !match32 && cnt_reg[1] == CNT_MAX
        && !(acc_wr && wsel == 4'h5) |=> cnt_reg[2] == $past(cnt_reg[2]) + 16'h0001)
        else $error("chained carry lost"); // R11
    chain_flag_a: assert property (chain && inc[1] && match32 |=> flag_reg[FLG_UP])
        else $error("chained match missed upper flag"); // R13
    chain_lo_a: assert property (chain && !flag_reg[FLG_LO] |=> !flag_reg[FLG_LO])
        else $error("lower flag set while chained"); // R13
    adc_src_a: assert property (adc_trigger |-> $past(chain) && $past(match32))
        else $error("ADC trigger not from chained match"); // R18
    sync_only_a: assert property (con_reg[1][TCS_BIT] && !(pin_s2_reg[1] && !pin_old_reg[1])
        && !chain |-> !inc[1]) else $error("lower counted without synced edge"); // R16

    match_c: cover property (inc[0] && match16[0]);
    chain_c: cover property (chain && inc[1] && match32);
    gate_c: cover property (gate_fall[0]);
    async_c: cover property (g_front[0].use_async && inc[0]);

endmodule

`default_nettype wire

/* File: tb/gts_testbench.sv */
/*
 * Self-checking bench for the general timer set: APB master tasks, a
 * queue-fed monitor for every transfer, timebase step measurement and
 * chained 32-bit wrap checks.
 * Assumes the design answers APB in the first access cycle and that the
 * count pins, power-mode levels and gates are synchronous to mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import gts_pkg::*;

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic pin = 1'b0;
    logic lvl = 1'b0;
    logic tog = 1'b0;
    logic idle = 1'b0;
    logic sleep = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, timer1_irq, lower_irq, upper_irq, adc_trigger;
    logic [15:0] lower_timebase, upper_timebase;
    logic [33:0] exp_q[$];
    logic [33:0] ent;
    logic [7:0] cyc = 8'h00;
    int error_cnt = 0;
    int tests_run = 0;
    int adc_cnt = 0;
    int seed = 32'h17013E70;
    // Lower-timer configurations: control word, mode bits, cycles per count
    logic [15:0] cfg_ctrl [11] = '{16'h8000, 16'h8010, 16'h8020, 16'h8030, 16'h0000,
        16'hA000, 16'h8000, 16'h8040, 16'h8040, 16'h8002, 16'h8000};
    logic [3:0] cfg_mode [11] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h8, 4'h0, 4'h1,
        4'h2, 4'h4};
    int cfg_step [11] = '{1, 8, 64, 256, 0, 0, 1, 0, 1, 4, 0};
    logic [31:0] chain_seq [6] = '{32'h0000FFFF, 32'h00010000, 32'h00010001,
        32'h00010002, 32'h00000000, 32'h00000001};
    logic [15:0] t1_cfg [2] = '{16'h8006, 16'h8002};

    gts_timer_set dut (
        .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer1_count_pin(pin),
        .timer2_count_pin(pin), .timer3_count_pin(pin), .idle_mode(idle),
        .sleep_mode(sleep), .timer1_irq(timer1_irq), .lower_irq(lower_irq),
        .upper_irq(upper_irq), .adc_trigger(adc_trigger),
        .lower_timebase(lower_timebase), .upper_timebase(upper_timebase)
    );

    // 100 MHz clock
    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // Count pin: rises every fourth cycle while toggling, else held level
    always @(posedge mclk)
    begin
        cyc <= cyc + 8'h01;
        pin <= tog ? cyc[1] : lvl;
        if (adc_trigger === 1'b1)
            adc_cnt <= adc_cnt + 1;
    end

    task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", name, e, s);
        end
    endtask

    // Monitor: every completed transfer takes the oldest note off the queue
    always @(posedge mclk)
    begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
        begin
            ent = exp_q.pop_front();
            check("pslverr", {31'h0, ent[32]}, {31'h0, pslverr});
            if (ent[33])
                check("prdata", ent[31:0], prdata);
        end
    end

    // One APB transfer; the wait is bounded so a dead slave cannot hang us
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic err);
        int n;
        begin
            n = 0;
            @(posedge mclk);
            exp_q.push_back({~wr, err, e});
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            @(posedge mclk);
            while (pready !== 1'b1 && n < 20)
            begin
                @(posedge mclk);
                n++;
            end
            check("pready", 32'h0, (n == 20) ? 32'h1 : 32'h0);
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask

    // Cycles between two timebase changes; zero means it must stand still
    task automatic step(input int ex);
        logic [15:0] v;
        int n;
        begin
            repeat (4) @(posedge mclk);
            v = lower_timebase;
            n = 0;
            if (ex == 0)
            begin
                repeat (40) @(posedge mclk);
                check("stalled", {16'h0, v}, {16'h0, lower_timebase});
            end
            else
            begin
                while (lower_timebase === v && n < 600)
                begin
                    @(posedge mclk);
                    n++;
                end
                v = lower_timebase;
                n = 0;
                while (lower_timebase === v && n < 600)
                begin
                    @(posedge mclk);
                    n++;
                end
                check("step", ex, n);
            end
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog, well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        conclude();
    end

    // Main sequence
    initial
    begin
        int n;
        logic [31:0] d;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        // Reset values, offsets run in steps of one word
        for (int i = 0; i < 11; i++)
            rd(8'(i * 4), (i == 2 || i == 7 || i == 8) ? 32'h0000FFFF : 32'h0);
        // Writable bits of the control registers, random data
        for (int i = 0; i < 3; i++)
        begin
            d = $random(seed);
            wr(i == 0 ? OFS_T1_CTRL : (i == 1 ? OFS_T2_CTRL : OFS_T3_CTRL), d);
            rd(i == 0 ? OFS_T1_CTRL : (i == 1 ? OFS_T2_CTRL : OFS_T3_CTRL),
                {16'h0, d[15:0] & (i == 0 ? T1_MASK : (i == 1 ? T2_MASK : T3_MASK))});
            wr(i == 0 ? OFS_T1_CTRL : (i == 1 ? OFS_T2_CTRL : OFS_T3_CTRL), 32'h0);
        end
        apb(1'b1, 8'h2C, 32'h0000FFFF, 32'h0, 1'b1);
        apb(1'b0, 8'h2C, 32'h0, 32'h0, 1'b1);
        // Lower timer: prescale, run, idle, gate, pin clock and sleep
        for (int i = 0; i < 11; i++)
        begin
            @(posedge mclk);
            idle <= cfg_mode[i][3];
            sleep <= cfg_mode[i][2];
            tog <= cfg_mode[i][1];
            lvl <= cfg_mode[i][0];
            wr(OFS_T2_CTRL, {16'h0, cfg_ctrl[i]});
            step(cfg_step[i]);
        end
        @(posedge mclk);
        sleep <= 1'b0;
        // Lower wraps to zero after matching a small period
        wr(OFS_T2_CTRL, 32'h0);
        wr(OFS_LO_CNT, 32'h0);
        wr(OFS_LO_PER, 32'h3);
        wr(OFS_IRQ_EN, 32'h7);
        wr(OFS_T2_CTRL, 32'h8000);
        n = 0;
        while (lower_timebase !== 16'h0003 && n < 50)
        begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
        check("wrap", 32'h0, {16'h0, lower_timebase});
        repeat (3) @(posedge mclk);
        check("lower_irq", 32'h1, {31'h0, lower_irq});
        rd(OFS_FLAGS, 32'h2);
        wr(OFS_T2_CTRL, 32'h0);
        wr(OFS_FLAGS, 32'h7);
        rd(OFS_FLAGS, 32'h0);
        check("lower_irq", 32'h0, {31'h0, lower_irq});
        check("adc_16bit", 32'h0, adc_cnt);
        // Chained pair set up with the run bit last, upper controls ignored
        wr(OFS_T2_CTRL, 32'h0008);
        wr(OFS_T3_CTRL, 32'h0030);
        wr(OFS_LO_CNT, 32'hFFFD);
        wr(OFS_UP_CNT, 32'h0);
        wr(OFS_LO_PER, 32'h2);
        wr(OFS_UP_PER, 32'h1);
        rd(OFS_LO_CNT, 32'hFFFD);
        rd(OFS_UP_CNT, 32'h0);
        wr(OFS_IRQ_EN, 32'h6);
        wr(OFS_T2_CTRL, 32'h8008);
        n = 0;
        while ({upper_timebase, lower_timebase} !== 32'h0000FFFE && n < 50)
        begin
            @(posedge mclk);
            n++;
        end
        for (int i = 0; i < 6; i++)
        begin
            @(posedge mclk);
            check("chain", chain_seq[i], {upper_timebase, lower_timebase});
        end
        repeat (3) @(posedge mclk);
        check("adc_chain", 32'h1, adc_cnt);
        check("upper_irq", 32'h1, {31'h0, upper_irq});
        check("lower_irq", 32'h0, {31'h0, lower_irq});
        wr(OFS_T2_CTRL, 32'h0);
        // Timer1 on its pin, synchronised and then asynchronous in sleep
        for (int i = 0; i < 2; i++)
        begin
            @(posedge mclk);
            tog <= 1'b0;
            lvl <= 1'b0;
            sleep <= (i == 1);
            wr(OFS_T1_CTRL, 32'h0);
            wr(OFS_T1_CNT, 32'h0);
            wr(OFS_T1_PER, 32'h1);
            wr(OFS_IRQ_EN, 32'h1);
            wr(OFS_FLAGS, 32'h7);
            wr(OFS_T1_CTRL, {16'h0, t1_cfg[i]});
            repeat (30) @(posedge mclk);
            check("t1_idle_pin", 32'h0, {31'h0, timer1_irq});
            tog <= 1'b1;
            n = 0;
            while (timer1_irq !== 1'b1 && n < 60)
            begin
                @(posedge mclk);
                n++;
            end
            check("t1_irq", 32'h1, {31'h0, timer1_irq});
        end
        // Upper timer alone, gated by its pin: each gate fall raises its flag
        @(posedge mclk);
        sleep <= 1'b0;
        wr(OFS_T1_CTRL, 32'h0);
        wr(OFS_IRQ_EN, 32'h4);
        wr(OFS_FLAGS, 32'h7);
        wr(OFS_T3_CTRL, 32'h8040);
        n = 0;
        while (upper_irq !== 1'b1 && n < 60)
        begin
            @(posedge mclk);
            n++;
        end
        check("up_gate_irq", 32'h1, {31'h0, upper_irq});
        rd(OFS_FLAGS, 32'h4);
        conclude();
    end
endmodule

`default_nettype wire
